// *** core/npc_cmd.sv ***
// Command handler for the identifier, radio, network and discovery commands.
// Assumes frames arrive as a byte stream on clk_sys, command byte first,
// from logic in the same clock domain; in_last marks the final byte.
//
// What this block does
// RULE1 - A valid identifier takes effect at once, with no network reset.
// RULE2 - The identifier command carries exactly one two-byte field.
// RULE3 - Identifier 0xFFFF is refused with code 3.
// RULE4 - Short frame gives 1, long frame 2; success 0 only if acks enabled.
// RULE5 - Channel, modulation and power apply together, or none on any fault.
// RULE6 - Channel 0, 100-102 or 1-10 accepted; others give code 24.
// RULE7 - Modulation zero selects BPSK, anything else QPSK; default BPSK.
// RULE8 - Power capped at 10 on North American, 5 on European; else 25.
// RULE9 - Network command sets all valid parameters and triggers a network reset.
// RULE10 - Socket limit defaults to 4; above 251 gives code 26 when no other field fails.
// RULE11 - Neighbour cache defaults to 4 and never drops below one.
// RULE12 - Reachable time is two bytes, default 3600 seconds.
// RULE13 - Hop limit defaults to 8; zero disables mesh forwarding.
// RULE14 - Routing table size is two bytes, at least 1, default 8.
// RULE15 - Route timeout is two bytes, default 3600 seconds.
// RULE16 - Forwarding failure and route attempt limits both default to 3.
// RULE17 - Minimum link strength defaults to -128, reduction step to 0.
// RULE18 - Duplicate detection and router solicitation flags default true.
// RULE19 - Bad parameters are ignored and reported as code 29 with a mask, except a lone socket fault.
// RULE20 - Network fields come in index order, three of them two bytes.
// RULE21 - Discovery command starts a network discovery with a time limit.
// RULE22 - Missing or zero discovery limit becomes 3.
// RULE23 - Length is checked before any field value.
module npc_cmd (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic in_last,
  output logic in_ready,
  input wire logic ack_en,
  output logic resp_valid,
  output logic [7:0] resp_code,
  output logic [15:0] resp_mask,
  output logic [15:0] pan_id,
  output logic [7:0] rf_channel,
  output logic rf_qpsk,
  output logic [7:0] rf_power,
  output logic [7:0] net_sock_max,
  output logic [7:0] net_ncache,
  output logic [15:0] net_reach_time,
  output logic [7:0] net_hop_max,
  output logic net_mesh_en,
  output logic [15:0] net_rt_size,
  output logic [15:0] net_rt_timeout,
  output logic [7:0] net_rt_fail_max,
  output logic [7:0] net_rssi_min,
  output logic [7:0] net_rssi_red,
  output logic [7:0] net_rreq_max,
  output logic net_dad_en,
  output logic net_rsol_en,
  output logic net_reset,
  output logic disc_start,
  output logic [7:0] disc_limit
);
  import npc_pkg::*;

  typedef struct packed {
    npc_state_e_t st;
    logic [7:0] cmd;
    logic [4:0] cnt;
    npc_buf_t abuf;
    logic resp_valid;
    logic [7:0] resp_code;
    logic [15:0] resp_mask;
    logic [15:0] pan;
    logic [7:0] chan;
    logic qpsk;
    logic [7:0] pwr;
    logic [7:0] sock;
    logic [7:0] ncache;
    logic [15:0] reach;
    logic [7:0] hops;
    logic [15:0] rtsize;
    logic [15:0] rtto;
    logic [7:0] rfail;
    logic [7:0] rssi;
    logic [7:0] rssi_red;
    logic [7:0] rreq;
    logic dad;
    logic rsol;
    logic net_reset;
    logic disc_start;
    logic [7:0] disc_limit;
  } npc_s_t;

  npc_s_t s_reg;
  npc_s_t s_next;
  logic [1:0] rst_q_reg;
  logic rst_ok;

  // Two-byte fields travel high byte first
  function automatic logic [15:0] get16(input npc_buf_t b, input int pos);
    get16 = {b[pos], b[pos + 1]};
  endfunction : get16

  function automatic logic chan_us(input logic [7:0] ch);
    chan_us = (ch >= CH_US_LO) && (ch <= CH_US_HI);
  endfunction : chan_us

  function automatic logic chan_ok(input logic [7:0] ch);
    chan_ok = chan_us(ch) || (ch == CH_EU_BASE) || ((ch >= CH_EU_LO) && (ch <= CH_EU_HI));
  endfunction : chan_ok

  function automatic logic [7:0] pwr_cap(input logic [7:0] ch);
    pwr_cap = chan_us(ch) ? PWR_MAX_US : PWR_MAX_EU;
  endfunction : pwr_cap

  // Reset release is synchronised so all state leaves reset on one edge
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_q_reg <= 2'h0;
    end else begin
      rst_q_reg <= {rst_q_reg[0], 1'b1};
    end
  end
  assign rst_ok = rst_q_reg[1];

  // No byte is taken while a finished frame is being executed
  assign in_ready = (s_reg.st != ST_EXEC);

  always_comb begin
    logic [4:0] lmin;
    logic [4:0] lmax;
    logic known;
    logic ok;
    logic [15:0] id;
    logic [15:0] mask;
    lmin = 5'h00;
    lmax = 5'h00;
    known = 1'b1;
    ok = 1'b0;
    id = 16'h0000;
    mask = 16'h0000;
    s_next = s_reg;
    s_next.resp_valid = 1'b0;
    s_next.net_reset = 1'b0;
    s_next.disc_start = 1'b0;
    unique case (s_reg.st)
      ST_IDLE: begin
        if (in_valid) begin
          s_next.cmd = in_data;
          s_next.cnt = 5'h00;
          s_next.st = in_last ? ST_EXEC : ST_ARGS;
        end
      end
      ST_ARGS: begin
        if (in_valid) begin
          // Bytes past the longest block are only counted
          if (s_reg.cnt < LEN_NET) begin
            s_next.abuf[s_reg.cnt[3:0]] = in_data;
          end
          if (s_reg.cnt != CNT_SAT) begin
            s_next.cnt = s_reg.cnt + 5'h01;
          end
          if (in_last) begin
            s_next.st = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        s_next.st = ST_IDLE;
        unique case (s_reg.cmd)
          CMD_SET_PAN: begin
            lmin = LEN_PAN; // see RULE2
            lmax = LEN_PAN;
          end
          CMD_PHY: begin
            lmin = LEN_PHY;
            lmax = LEN_PHY;
          end
          CMD_NET: begin
            lmin = LEN_NET; // see RULE20
            lmax = LEN_NET;
          end
          CMD_DISC: begin
            lmin = LEN_DISC_MIN;
            lmax = LEN_DISC_MAX;
          end
          default: known = 1'b0;
        endcase
        if (known) begin
          s_next.resp_mask = 16'h0000;
          s_next.resp_valid = 1'b1;
          if (s_reg.cnt < lmin) begin
            s_next.resp_code = RC_SHORT; // see RULE4, RULE23
          end else if (s_reg.cnt > lmax) begin
            s_next.resp_code = RC_LONG; // see RULE4, RULE23
          end else begin
            unique case (s_reg.cmd)
              CMD_SET_PAN: begin
                id = get16(s_reg.abuf, 0);
                if (id == PAN_INVALID) begin
                  s_next.resp_code = RC_BAD_PAN; // see RULE3
                end else begin
                  s_next.pan = id; // see RULE1
                  ok = 1'b1;
                end
              end
              CMD_PHY: begin
                // Channel and power checked before any of the three fields is applied
                if (!chan_ok(s_reg.abuf[0])) begin
                  s_next.resp_code = RC_BAD_CHAN; // see RULE6
                end else if (s_reg.abuf[2] > pwr_cap(s_reg.abuf[0])) begin
                  s_next.resp_code = RC_BAD_PWR; // see RULE8
                end else begin
                  s_next.chan = s_reg.abuf[0]; // see RULE5
                  s_next.qpsk = (s_reg.abuf[1] != 8'h00); // see RULE7
                  s_next.pwr = s_reg.abuf[2];
                  ok = 1'b1;
                end
              end
              CMD_NET: begin
                if (s_reg.abuf[POS_SOCK] > SOCK_MAX) begin
                  mask[IDX_SOCK] = 1'b1; // see RULE10
                end else begin
                  s_next.sock = s_reg.abuf[POS_SOCK];
                end
                if (s_reg.abuf[POS_NCACHE] == 8'h00) begin
                  mask[IDX_NCACHE] = 1'b1; // see RULE11
                end else begin
                  s_next.ncache = s_reg.abuf[POS_NCACHE];
                end
                s_next.reach = get16(s_reg.abuf, POS_REACH); // see RULE12
                s_next.hops = s_reg.abuf[POS_HOPS]; // see RULE13
                if (get16(s_reg.abuf, POS_RTSIZE) == 16'h0000) begin
                  mask[IDX_RTSIZE] = 1'b1; // see RULE14
                end else begin
                  s_next.rtsize = get16(s_reg.abuf, POS_RTSIZE);
                end
                s_next.rtto = get16(s_reg.abuf, POS_RTTO); // see RULE15
                s_next.rfail = s_reg.abuf[POS_RFAIL]; // see RULE16
                s_next.rssi = s_reg.abuf[POS_RSSI]; // see RULE17
                s_next.rssi_red = s_reg.abuf[POS_RED];
                s_next.rreq = s_reg.abuf[POS_RREQ]; // see RULE16
                s_next.dad = (s_reg.abuf[POS_DAD] != 8'h00); // see RULE18
                s_next.rsol = (s_reg.abuf[POS_RSOL] != 8'h00);
                s_next.net_reset = 1'b1; // see RULE9
                // A lone socket fault keeps its own code
                if (mask == 16'h0000) begin
                  ok = 1'b1;
                end else if (mask == MASK_SOCK_ONLY) begin
                  s_next.resp_code = RC_SOCK; // see RULE10
                end else begin
                  s_next.resp_code = RC_MASK; // see RULE19
                  s_next.resp_mask = mask;
                end
              end
              CMD_DISC: begin
                s_next.disc_start = 1'b1; // see RULE21
                if ((s_reg.cnt == 5'h00) || (s_reg.abuf[0] == 8'h00)) begin
                  s_next.disc_limit = DEF_DISC_LIMIT; // see RULE22
                end else begin
                  s_next.disc_limit = s_reg.abuf[0];
                end
                ok = 1'b1;
              end
              default: ok = 1'b0;
            endcase
            if (ok) begin
              s_next.resp_code = RC_OK;
              s_next.resp_valid = ack_en; // see RULE4
            end
          end
        end
      end
      default: s_next.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_ok) begin
    if (!rst_ok) begin
      s_reg <= '0;
      s_reg.st <= ST_IDLE;
      s_reg.pan <= DEF_PAN;
      s_reg.chan <= DEF_CHAN; // see RULE6
      s_reg.qpsk <= DEF_QPSK; // see RULE7
      s_reg.pwr <= DEF_PWR; // see RULE8
      s_reg.sock <= DEF_SOCK; // see RULE10
      s_reg.ncache <= DEF_NCACHE; // see RULE11
      s_reg.reach <= DEF_REACH; // see RULE12
      s_reg.hops <= DEF_HOPS; // see RULE13
      s_reg.rtsize <= DEF_RTSIZE; // see RULE14
      s_reg.rtto <= DEF_RTTO; // see RULE15
      s_reg.rfail <= DEF_RFAIL; // see RULE16
      s_reg.rssi <= DEF_RSSI; // see RULE17
      s_reg.rssi_red <= DEF_RSSI_RED;
      s_reg.rreq <= DEF_RREQ;
      s_reg.dad <= DEF_DAD; // see RULE18
      s_reg.rsol <= DEF_RSOL;
      s_reg.disc_limit <= DEF_DISC_LIMIT;
    end else begin
      s_reg <= s_next;
    end
  end

  assign resp_valid = s_reg.resp_valid;
  assign resp_code = s_reg.resp_code;
  assign resp_mask = s_reg.resp_mask;
  assign pan_id = s_reg.pan;
  assign rf_channel = s_reg.chan;
  assign rf_qpsk = s_reg.qpsk;
  assign rf_power = s_reg.pwr;
  assign net_sock_max = s_reg.sock;
  assign net_ncache = s_reg.ncache;
  assign net_reach_time = s_reg.reach;
  assign net_hop_max = s_reg.hops;
  assign net_mesh_en = (s_reg.hops != 8'h00); // see RULE13
  assign net_rt_size = s_reg.rtsize;
  assign net_rt_timeout = s_reg.rtto;
  assign net_rt_fail_max = s_reg.rfail;
  assign net_rssi_min = s_reg.rssi;
  assign net_rssi_red = s_reg.rssi_red;
  assign net_rreq_max = s_reg.rreq;
  assign net_dad_en = s_reg.dad;
  assign net_rsol_en = s_reg.rsol;
  assign net_reset = s_reg.net_reset;
  assign disc_start = s_reg.disc_start;
  assign disc_limit = s_reg.disc_limit;

  a_pan_apply: assert property (@(posedge clk_sys) disable iff (!rst_ok) // see RULE1
    (s_reg.st == ST_EXEC && s_reg.cmd == CMD_SET_PAN && s_reg.cnt == LEN_PAN
      && get16(s_reg.abuf, 0) != PAN_INVALID)
    |=> (pan_id == $past(get16(s_reg.abuf, 0))) && !net_reset)
    else $error("identifier not applied");
  a_pan_never_ones: assert property (@(posedge clk_sys) disable iff (!rst_ok) // see RULE3
    pan_id != PAN_INVALID)
    else $error("all-ones identifier stored");
  a_len_short: assert property (@(posedge clk_sys) disable iff (!rst_ok) // see RULE23
    (s_reg.st == ST_EXEC && s_reg.cmd == CMD_PHY && s_reg.cnt < LEN_PHY)
    |=> resp_valid && resp_code == RC_SHORT && $stable(rf_channel))
    else $error("short frame not reported");
  a_ack_gate: assert property (@(posedge clk_sys) disable iff (!rst_ok) // see RULE4
    (resp_valid && resp_code == RC_OK) |-> $past(ack_en))
    else $error("success sent with acks off");
  a_phy_atomic: assert property (@(posedge clk_sys) disable iff (!rst_ok) // see RULE5
    (resp_valid && (resp_code == RC_BAD_CHAN || resp_code == RC_BAD_PWR))
    |-> $stable(rf_channel) && $stable(rf_qpsk) && $stable(rf_power))
    else $error("radio fields changed on fault");
  a_power_cap: assert property (@(posedge clk_sys) disable iff (!rst_ok) // see RULE8
    chan_ok(rf_channel) && rf_power <= pwr_cap(rf_channel))
    else $error("radio channel or power out of range");
  a_net_reset: assert property (@(posedge clk_sys) disable iff (!rst_ok) // see RULE9
    (s_reg.st == ST_EXEC && s_reg.cmd == CMD_NET && s_reg.cnt == LEN_NET)
    |=> net_reset ##1 !net_reset)
    else $error("network reset not pulsed");
  a_net_limits: assert property (@(posedge clk_sys) disable iff (!rst_ok) // see RULE10
    net_sock_max <= SOCK_MAX && net_ncache != 8'h00 && net_rt_size != 16'h0000)
    else $error("network parameter out of range");
  a_mask_code: assert property (@(posedge clk_sys) disable iff (!rst_ok) // see RULE19
    (resp_valid && resp_mask != 16'h0000) |-> resp_code == RC_MASK && net_reset)
    else $error("mask without code 29");
  a_disc_limit: assert property (@(posedge clk_sys) disable iff (!rst_ok) // see RULE22
    disc_start |-> disc_limit != 8'h00)
    else $error("zero discovery limit");
endmodule : npc_cmd

// *** common/npc_pkg.sv ***
// Constants for the network and radio configuration command handler.
// Assumes a framing layer upstream that delivers unescaped, checksummed frames.
package npc_pkg;
  // Command identifiers; arbitrary values chosen for this handler
  localparam logic [7:0] CMD_SET_PAN = 8'h09;
  localparam logic [7:0] CMD_PHY = 8'h0A;
  localparam logic [7:0] CMD_NET = 8'h0B;
  localparam logic [7:0] CMD_DISC = 8'h0C;
  // Argument lengths in bytes, command byte excluded
  localparam logic [4:0] LEN_PAN = 5'h02;
  localparam logic [4:0] LEN_PHY = 5'h03;
  localparam logic [4:0] LEN_NET = 5'h0F;
  localparam logic [4:0] LEN_DISC_MIN = 5'h00;
  localparam logic [4:0] LEN_DISC_MAX = 5'h01;
  localparam logic [4:0] CNT_SAT = 5'h1F;
  localparam int BUF_N = 15;
  // Response codes
  localparam logic [7:0] RC_OK = 8'h00;
  localparam logic [7:0] RC_SHORT = 8'h01;
  localparam logic [7:0] RC_LONG = 8'h02;
  localparam logic [7:0] RC_BAD_PAN = 8'h03;
  localparam logic [7:0] RC_BAD_CHAN = 8'h18;
  localparam logic [7:0] RC_BAD_PWR = 8'h19;
  localparam logic [7:0] RC_SOCK = 8'h1A;
  localparam logic [7:0] RC_MASK = 8'h1D;
  // Value limits
  localparam logic [15:0] PAN_INVALID = 16'hFFFF;
  localparam logic [7:0] CH_EU_BASE = 8'h00;
  localparam logic [7:0] CH_EU_LO = 8'h64;
  localparam logic [7:0] CH_EU_HI = 8'h66;
  localparam logic [7:0] CH_US_LO = 8'h01;
  localparam logic [7:0] CH_US_HI = 8'h0A;
  localparam logic [7:0] PWR_MAX_US = 8'h0A;
  localparam logic [7:0] PWR_MAX_EU = 8'h05;
  localparam logic [7:0] SOCK_MAX = 8'hFB;
  // Reset values
  localparam logic [15:0] DEF_PAN = 16'h0000;
  localparam logic [7:0] DEF_CHAN = 8'h00;
  localparam logic DEF_QPSK = 1'b0;
  localparam logic [7:0] DEF_PWR = 8'h00;
  localparam logic [7:0] DEF_SOCK = 8'h04;
  localparam logic [7:0] DEF_NCACHE = 8'h04;
  localparam logic [15:0] DEF_REACH = 16'h0E10;
  localparam logic [7:0] DEF_HOPS = 8'h08;
  localparam logic [15:0] DEF_RTSIZE = 16'h0008;
  localparam logic [15:0] DEF_RTTO = 16'h0E10;
  localparam logic [7:0] DEF_RFAIL = 8'h03;
  localparam logic [7:0] DEF_RSSI = 8'h80;
  localparam logic [7:0] DEF_RSSI_RED = 8'h00;
  localparam logic [7:0] DEF_RREQ = 8'h03;
  localparam logic DEF_DAD = 1'b1;
  localparam logic DEF_RSOL = 1'b1;
  localparam logic [7:0] DEF_DISC_LIMIT = 8'h03;
  // Byte positions inside the network parameter block
  localparam int POS_SOCK = 0;
  localparam int POS_NCACHE = 1;
  localparam int POS_REACH = 2;
  localparam int POS_HOPS = 4;
  localparam int POS_RTSIZE = 5;
  localparam int POS_RTTO = 7;
  localparam int POS_RFAIL = 9;
  localparam int POS_RSSI = 10;
  localparam int POS_RED = 11;
  localparam int POS_RREQ = 12;
  localparam int POS_DAD = 13;
  localparam int POS_RSOL = 14;
  // Mask bit for each parameter that can fail
  localparam int IDX_SOCK = 0;
  localparam int IDX_NCACHE = 1;
  localparam int IDX_RTSIZE = 4;
  localparam logic [15:0] MASK_SOCK_ONLY = 16'h0001;

  typedef logic [BUF_N-1:0][7:0] npc_buf_t;
  typedef enum logic [1:0] {ST_IDLE, ST_ARGS, ST_EXEC} npc_state_e_t;
endpackage : npc_pkg

// *** testbench/npc_host.sv ***
// Host model that feeds command frames byte by byte.
// Assumes the handler's in_ready is settled 1 ns after each rising edge.
module npc_host (
  input wire logic clk_sys,
  input wire logic in_ready,
  output logic in_valid,
  output logic [7:0] in_data,
  output logic in_last
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    in_valid = 1'b0;
    in_data = 8'h00;
    in_last = 1'b0;
  end
  // Bytes right aligned in b, first byte highest; gap adds idle cycles between bytes
  task automatic send(input int n, input logic [127:0] b, input int gap);
    for (int i = 0; i < n; i++) begin
      in_valid = 1'b1;
      in_data = b[8*(n-1-i) +: 8];
      in_last = (i == n - 1);
      while (in_ready !== 1'b1) begin
        @(posedge clk_sys);
        #1;
      end
      @(posedge clk_sys);
      #1;
      if (i == n - 1 || gap > 0) begin
        in_valid = 1'b0;
        in_last = 1'b0;
        // Released data shows the inverse so stale bytes never look valid
        in_data = ~in_data;
        if (i < n - 1) begin
          repeat (gap) @(posedge clk_sys);
          #1;
        end
      end
    end
  endtask : send
endmodule : npc_host

// *** testbench/tb_top.sv ***
// Self-checking bench for the command handler.
// Assumes one 100 MHz clock; the host model drives the frame input.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import npc_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn, ack_en, in_valid, in_last, in_ready, resp_valid, rf_qpsk, net_mesh_en;
  logic net_dad_en, net_rsol_en, net_reset, disc_start;
  logic [7:0] in_data, resp_code, rf_channel, rf_power, net_sock_max, net_ncache;
  logic [7:0] net_hop_max, net_rt_fail_max, net_rssi_min, net_rssi_red, net_rreq_max, disc_limit;
  logic [15:0] resp_mask, pan_id, net_reach_time, net_rt_size, net_rt_timeout;
  int n_errors = 0;
  int num_checks = 0;
  // Entries {code, channel, modulation, power}; the channel 0x0B fault carries bad power too
  localparam logic [32*13-1:0] PHY_T = {32'h18_0B_00_14, 32'h18_63_00_00, 32'h18_67_00_00,
    32'h18_FF_00_00, 32'h00_00_00_05, 32'h00_64_01_05, 32'h00_65_00_00, 32'h00_66_07_05,
    32'h00_01_00_0A, 32'h00_0A_01_0A, 32'h19_00_00_06, 32'h19_65_00_06, 32'h19_05_00_0B};

  always #5 clk_sys = ~clk_sys;

  npc_host host (.clk_sys(clk_sys), .in_ready(in_ready), .in_valid(in_valid),
    .in_data(in_data), .in_last(in_last));

  npc_cmd DUT (.clk_sys(clk_sys), .rstn(rstn), .in_valid(in_valid), .in_data(in_data),
    .in_last(in_last), .in_ready(in_ready), .ack_en(ack_en), .resp_valid(resp_valid),
    .resp_code(resp_code), .resp_mask(resp_mask), .pan_id(pan_id), .rf_channel(rf_channel),
    .rf_qpsk(rf_qpsk), .rf_power(rf_power), .net_sock_max(net_sock_max),
    .net_ncache(net_ncache), .net_reach_time(net_reach_time), .net_hop_max(net_hop_max),
    .net_mesh_en(net_mesh_en), .net_rt_size(net_rt_size), .net_rt_timeout(net_rt_timeout),
    .net_rt_fail_max(net_rt_fail_max), .net_rssi_min(net_rssi_min),
    .net_rssi_red(net_rssi_red), .net_rreq_max(net_rreq_max), .net_dad_en(net_dad_en),
    .net_rsol_en(net_rsol_en), .net_reset(net_reset), .disc_start(disc_start),
    .disc_limit(disc_limit));

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Called just after the edge taking the last byte; response stands one cycle later
  task automatic resp(input logic v, input logic [7:0] c, input logic [15:0] m,
      input logic nr, input logic ds);
    chk("in_ready execute", 1'b0, in_ready);
    @(posedge clk_sys);
    #1;
    chk("resp_valid", v, resp_valid);
    if (v) begin
      chk("resp_code", c, resp_code);
      chk("resp_mask", m, resp_mask);
    end
    chk("net_reset", nr, net_reset);
    chk("disc_start", ds, disc_start);
    @(posedge clk_sys);
    #1;
    chk("resp_valid low", 1'b0, resp_valid);
  endtask : resp

  task automatic t_defaults();
    chk("pan_id", 16'h0000, pan_id);
    chk("rf_channel", 8'h00, rf_channel);
    chk("rf_qpsk", 1'b0, rf_qpsk);
    chk("rf_power", 8'h00, rf_power);
    chk("net_sock_max", 8'h04, net_sock_max);
    chk("net_ncache", 8'h04, net_ncache);
    chk("net_reach_time", 16'h0E10, net_reach_time);
    chk("net_hop_max", 8'h08, net_hop_max);
    chk("net_mesh_en", 1'b1, net_mesh_en);
    chk("net_rt_size", 16'h0008, net_rt_size);
    chk("net_rt_timeout", 16'h0E10, net_rt_timeout);
    chk("net_rt_fail_max", 8'h03, net_rt_fail_max);
    chk("net_rreq_max", 8'h03, net_rreq_max);
    chk("net_rssi_min", 8'h80, net_rssi_min);
    chk("net_rssi_red", 8'h00, net_rssi_red);
    chk("net_dad_en", 1'b1, net_dad_en);
    chk("net_rsol_en", 1'b1, net_rsol_en);
    chk("disc_limit", 8'h03, disc_limit);
  endtask : t_defaults

  task automatic t_pan();
    host.send(2, {CMD_SET_PAN, 8'h12}, 0);
    resp(1'b1, 8'h01, 16'h0000, 1'b0, 1'b0);
    host.send(4, {CMD_SET_PAN, 16'hFFFF, 8'h00}, 0);
    resp(1'b1, 8'h02, 16'h0000, 1'b0, 1'b0);
    host.send(3, {CMD_SET_PAN, 16'hFFFF}, 0);
    resp(1'b1, 8'h03, 16'h0000, 1'b0, 1'b0);
    chk("pan_id", 16'h0000, pan_id);
    // Slow host: idle cycles between bytes
    host.send(3, {CMD_SET_PAN, 16'hA5C3}, 2);
    resp(1'b1, 8'h00, 16'h0000, 1'b0, 1'b0);
    chk("pan_id", 16'hA5C3, pan_id);
  endtask : t_pan

  task automatic t_phy();
    logic [31:0] e;
    logic [7:0] ch = 8'h00;
    logic q = 1'b0;
    logic [7:0] pw = 8'h00;
    for (int i = 12; i >= 0; i--) begin
      e = PHY_T[32*i +: 32];
      host.send(4, {CMD_PHY, e[23:0]}, 0);
      resp(1'b1, e[31:24], 16'h0000, 1'b0, 1'b0);
      if (e[31:24] == 8'h00) begin
        ch = e[23:16];
        q = (e[15:8] != 8'h00);
        pw = e[7:0];
      end
      chk("rf_channel", ch, rf_channel);
      chk("rf_qpsk", q, rf_qpsk);
      chk("rf_power", pw, rf_power);
    end
    host.send(3, {CMD_PHY, 16'h0B00}, 0);
    resp(1'b1, 8'h01, 16'h0000, 1'b0, 1'b0);
    host.send(5, {CMD_PHY, 32'h03000200}, 0);
    resp(1'b1, 8'h02, 16'h0000, 1'b0, 1'b0);
    ack_en = 1'b0;
    host.send(4, {CMD_PHY, 24'h030002}, 0);
    resp(1'b0, 8'h00, 16'h0000, 1'b0, 1'b0);
    chk("rf_channel", 8'h03, rf_channel);
    ack_en = 1'b1;
  endtask : t_phy

  task automatic t_net();
    host.send(16, {CMD_NET, 48'hFB_01_1234_00_00, 72'h01_0102_05_9C_02_07_00_00}, 0);
    resp(1'b1, 8'h00, 16'h0000, 1'b1, 1'b0);
    chk("net_sock_max", 8'hFB, net_sock_max);
    chk("net_ncache", 8'h01, net_ncache);
    chk("net_reach_time", 16'h1234, net_reach_time);
    chk("net_mesh_en", 1'b0, net_mesh_en);
    chk("net_rt_size", 16'h0001, net_rt_size);
    chk("net_rt_timeout", 16'h0102, net_rt_timeout);
    chk("net_rt_fail_max", 8'h05, net_rt_fail_max);
    chk("net_rssi_min", 8'h9C, net_rssi_min);
    chk("net_rssi_red", 8'h02, net_rssi_red);
    chk("net_rreq_max", 8'h07, net_rreq_max);
    chk("net_dad_en", 1'b0, net_dad_en);
    chk("net_rsol_en", 1'b0, net_rsol_en);
    host.send(16, {CMD_NET, 48'hFC_02_1234_00_00, 72'h01_0102_05_9C_02_07_00_00}, 0);
    resp(1'b1, 8'h1A, 16'h0000, 1'b1, 1'b0);
    chk("net_sock_max", 8'hFB, net_sock_max);
    chk("net_ncache", 8'h02, net_ncache);
    host.send(16, {CMD_NET, 48'h10_00_1234_03_00, 72'h00_0102_05_9C_02_07_05_00}, 0);
    resp(1'b1, 8'h1D, 16'h0012, 1'b1, 1'b0);
    chk("net_sock_max", 8'h10, net_sock_max);
    chk("net_ncache", 8'h02, net_ncache);
    chk("net_rt_size", 16'h0001, net_rt_size);
    chk("net_hop_max", 8'h03, net_hop_max);
    chk("net_dad_en", 1'b1, net_dad_en);
    host.send(2, {CMD_NET, 8'h00}, 0);
    resp(1'b1, 8'h01, 16'h0000, 1'b0, 1'b0);
  endtask : t_net

  task automatic t_disc();
    host.send(1, {CMD_DISC}, 0);
    resp(1'b1, 8'h00, 16'h0000, 1'b0, 1'b1);
    chk("disc_limit", 8'h03, disc_limit);
    host.send(2, {CMD_DISC, 8'h07}, 0);
    resp(1'b1, 8'h00, 16'h0000, 1'b0, 1'b1);
    chk("disc_limit", 8'h07, disc_limit);
    host.send(2, {CMD_DISC, 8'h00}, 0);
    resp(1'b1, 8'h00, 16'h0000, 1'b0, 1'b1);
    chk("disc_limit", 8'h03, disc_limit);
    host.send(3, {CMD_DISC, 16'h0505}, 0);
    resp(1'b1, 8'h02, 16'h0000, 1'b0, 1'b0);
    // Unknown command id: no response and no pulse
    host.send(2, {8'h55, 8'h00}, 0);
    resp(1'b0, 8'h00, 16'h0000, 1'b0, 1'b0);
  endtask : t_disc

  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  initial begin
    rstn = 1'b0;
    ack_en = 1'b1;
    repeat (10) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    t_defaults();
    t_pan();
    t_phy();
    t_net();
    t_disc();
    finish_test();
  end

  // Whole run is well under 2,000 cycles
  initial begin
    #100us;
    n_errors++;
    finish_test();
  end
endmodule : tb_top
